// File: verilog/bst_pkg.sv
// constants and carrier types for the boundary-scan test access block
// assumes a 10 MHz system clock that oversamples the test clock pin
package bst_pkg;

   // instruction codes, three bits wide
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_SAMPLE = 3'h1;
   localparam logic [2:0] INS_CUSTOM_A = 3'h2;
   localparam logic [2:0] INS_CUSTOM_B = 3'h3;
   localparam logic [2:0] INS_READOUT = 3'h4;
   localparam logic [2:0] INS_CONFIGURE = 3'h5;
   localparam logic [2:0] INS_RESERVED = 3'h6;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam int IR_W = 3;
   // value loaded into the instruction shifter in capture-ir
   localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;

   // register map on the apb bus (byte addresses)
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   // control fields
   localparam int CTRL_KEEP_BIT = 0;
   localparam int CTRL_USER_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_IR_LSB = 16;
   localparam int STAT_DONE_BIT = 19;
   localparam int STAT_KEEP_BIT = 20;
   localparam int STAT_SPECIAL_BIT = 21;

   // tap controller states, one-hot
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SH_DR = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PAU_DR = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SH_IR = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PAU_IR = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } bst_tap_t;

   // hooks handed to custom test registers in user logic
   typedef struct packed {
      logic customInstrASelect;
      logic customInstrBSelect;
      logic dataRegClockExport;
      logic idleNandOutput;
      logic tapResetDecode;
      logic tapUpdateDecode;
      logic tapShiftDecode;
      logic scanIn;
   } bst_hooks_t;

endpackage : bst_pkg

// File: verilog/bst_tap_logic.sv
// boundary-scan test access port, instruction decode, boundary and
// bypass registers, user hooks and an apb control/status slave.
// assumes tck, tms, tdi and the done pin are asynchronous pins that the
// 10 MHz clk oversamples; the test clock must be much slower than clk.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - three-bit instruction register with fixed decode
// - extest, sample, bypass plus two custom instructions
// - readout to tdo; configure disables pin drive
// - separate select output per custom instruction
// - custom instruction takes tdo from its scan-out
// - export data register clock to user logic
// - idle output is nand of tck, idle state
// - reset, update, shift state decodes exported
// - three cells per io block, bonded or not
// - cell order enable, output, input
// - tdo enable bit0, tdo out bit1, update last
// - configuration pins have no boundary cells
// - extest capture-dr captures every cell
// - bypass is one flop from tdi to tdo
// - sixteen-state controller, instruction and data registers
// - no test reset pin; tms resets controller
// - tap pin cells force outputs off while scan is active
// - global clock inputs come straight from pins
// - after configuration custom instructions need design enable
// - cells chained from upper-right corner around edges
// - kept scan dedicates tap pins and tdo
module bst_tap_logic import bst_pkg::*; #(
   parameter int NUM_IOB = 8,
   parameter logic [NUM_IOB-1:0] TAP_IOB_MASK = '0,
   parameter logic [NUM_IOB-1:0] CLK_IOB_MASK = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // test access pins
   input wire logic tckPin,
   input wire logic tmsPin,
   input wire logic tdiPin,
   output logic tdoPin,
   output logic tdoPinOe,
   output logic tapPinsDedicated,
   // configuration side
   input wire logic configDonePin,
   input wire logic readbackData,
   input wire logic configDout,
   output logic configLoadEnable,
   // io block pins and core side
   input wire logic [NUM_IOB-1:0] iobPinIn,
   output logic [NUM_IOB-1:0] iobPinOut,
   output logic [NUM_IOB-1:0] iobPinOe,
   input wire logic [NUM_IOB-1:0] coreOut,
   input wire logic [NUM_IOB-1:0] coreOe,
   output logic [NUM_IOB-1:0] coreIn,
   // custom test register hooks
   input wire logic customScanOutA,
   input wire logic customScanOutB,
   output bst_hooks_t userHooks
);

   // boundary length: two tdo bits, three per io block, update cell
   localparam int BLEN = 3 * NUM_IOB + 3;
   localparam int UPD_POS = BLEN - 1;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [3:0] syncA; // first stage, read only by syncB
   logic [3:0] syncB; // second stage
   logic tckPrev; // last sampled test clock level
   logic [2:0] syncPrimed; // fills with ones once both stages and tckPrev hold pins
   logic tckS, tmsS, tdiS, doneS;
   logic tckRise, tckFall;

   // two flops on each asynchronous pin before any logic sees it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= 4'h0;
         syncB <= 4'h0;
         tckPrev <= 1'b0;
         syncPrimed <= 3'h0;
      end else begin
         syncPrimed <= {syncPrimed[1:0], 1'b1};
         syncA <= {configDonePin, tdiPin, tmsPin, tckPin};
         syncB <= syncA;
         tckPrev <= syncB[0];
      end
   end
   assign tckS = syncB[0];
   assign tmsS = syncB[1];
   assign tdiS = syncB[2];
   assign doneS = syncB[3];
   // tck may rest at either level but the detector resets low, so edges
   // wait until syncB and tckPrev both hold real pin samples
   assign tckRise = tckS & ~tckPrev & syncPrimed[2];
   assign tckFall = ~tckS & tckPrev & syncPrimed[2];

   ////////////////////////////////////////////////////////////////////
   // control register and availability
   logic [1:0] ctrl; // keep-scan and custom-enable bits
   logic scanActive; // tap usable at all
   assign scanActive = ~doneS | ctrl[CTRL_KEEP_BIT];
   // kept scan turns three user pins into tap inputs and one into tdo
   assign tapPinsDedicated = ctrl[CTRL_KEEP_BIT];

   ////////////////////////////////////////////////////////////////////
   // tap controller
   bst_tap_t tapState;
   bst_tap_t next_tapState;

   function automatic bst_tap_t tapStep(bst_tap_t s, logic m);
      bst_tap_t n;
      n = TAP_RESET;
      unique case (s)
         TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: n = m ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: n = m ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: n = m ? TAP_SEL_IR : TAP_IDLE;
         default: n = TAP_RESET;
      endcase
      return n;
   endfunction : tapStep

   assign next_tapState = tapStep(tapState, tmsS);
   // no reset pin: only tms walks it home, or loss of availability
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tapState <= TAP_RESET;
      end else if (!scanActive) begin
         tapState <= TAP_RESET;
      end else if (tckRise) begin
         tapState <= next_tapState;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // instruction register
   logic [IR_W-1:0] irShift; // shift stage
   logic [IR_W-1:0] irReg; // latched instruction
   logic [IR_W-1:0] activeInstr; // instruction after availability
   logic userEn;

   // shift on rising test clock, latch on falling in update-ir
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irShift <= INS_BYPASS;
         irReg <= INS_BYPASS;
      end else if (tapState == TAP_RESET) begin
         irReg <= INS_BYPASS;
      end else if (tckRise && tapState == TAP_CAP_IR) begin
         irShift <= IR_CAPTURE_VAL;
      end else if (tckRise && tapState == TAP_SH_IR) begin
         irShift <= {tdiS, irShift[IR_W-1:1]};
      end else if (tckFall && tapState == TAP_UPD_IR) begin
         irReg <= irShift;
      end
   end

   // custom codes need the design's enable once configured
   assign userEn = ~doneS | ctrl[CTRL_USER_BIT];
   always_comb begin
      activeInstr = irReg;
      if (irReg == INS_RESERVED) begin
         activeInstr = INS_BYPASS;
      end else if (!userEn &&
                   (irReg == INS_CUSTOM_A || irReg == INS_CUSTOM_B)) begin
         activeInstr = INS_BYPASS;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // boundary register: io block k at 2+3k enable, 3+3k out, 4+3k in;
   // block 0 is the upper-right corner, then top edge right to left,
   // left edge down, bottom edge left to right, right edge up.
   // configuration clear, clock and done pins carry no cells.
   logic [BLEN-1:0] bsr; // shift/capture stage
   logic [BLEN-1:0] bsu; // update stage
   logic [BLEN-1:0] capVec; // values seen at capture
   logic bsrSel;
   logic extestOn;

   assign bsrSel = activeInstr == INS_EXTEST || activeInstr == INS_SAMPLE;
   assign extestOn = activeInstr == INS_EXTEST;
   assign capVec[0] = tdoPinOe;
   assign capVec[1] = tdoPin;
   assign capVec[UPD_POS] = bsu[UPD_POS];

   genvar k;
   generate
      for (k = 0; k < NUM_IOB; k++) begin : g_iob
         logic oeNow, outNow;
         // drive source: update cells under extest, else core logic
         always_comb begin
            oeNow = extestOn ? bsu[2 + 3 * k] : coreOe[k];
            outNow = extestOn ? bsu[3 + 3 * k] : coreOut[k];
            if (activeInstr == INS_CONFIGURE) begin
               oeNow = 1'b0;
            end
            // tap input pads never drive while scan is selected
            if (TAP_IOB_MASK[k] && scanActive) begin
               oeNow = 1'b0;
            end
         end
         assign iobPinOe[k] = oeNow;
         assign iobPinOut[k] = outNow;
         // capture what goes to the pad and what comes back
         assign capVec[2 + 3 * k] = oeNow;
         assign capVec[3 + 3 * k] = outNow;
         assign capVec[4 + 3 * k] = iobPinIn[k];
      end
   endgenerate

   // pad inputs reach the core untouched; clock pads in CLK_IOB_MASK
   // are only scan-driven through their own output driver
   assign coreIn = iobPinIn;

   // capture and shift on rising test clock, update on falling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bsr <= '0;
         bsu <= '0;
      end else if (bsrSel && tckRise && tapState == TAP_CAP_DR) begin
         bsr <= capVec;
      end else if (bsrSel && tckRise && tapState == TAP_SH_DR) begin
         bsr <= {tdiS, bsr[BLEN-1:1]};
      end else if (bsrSel && tckFall && tapState == TAP_UPD_DR) begin
         bsu <= bsr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bypass register
   logic bypassBit;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bypassBit <= 1'b0;
      end else if (activeInstr == INS_BYPASS && tckRise) begin
         if (tapState == TAP_CAP_DR) begin
            bypassBit <= 1'b0;
         end else if (tapState == TAP_SH_DR) begin
            bypassBit <= tdiS;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // test data out, changed on the falling test clock
   logic drBit;
   always_comb begin
      unique case (activeInstr)
         INS_EXTEST, INS_SAMPLE: drBit = bsr[0];
         INS_CUSTOM_A: drBit = customScanOutA;
         INS_CUSTOM_B: drBit = customScanOutB;
         INS_READOUT: drBit = readbackData;
         INS_CONFIGURE: drBit = configDout;
         default: drBit = bypassBit;
      endcase
   end

   // the enable is only high while a shift state owns the line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdoPin <= 1'b0;
         tdoPinOe <= 1'b0;
      end else if (tckFall) begin
         tdoPinOe <= scanActive &&
                     (tapState == TAP_SH_DR || tapState == TAP_SH_IR);
         if (tapState == TAP_SH_IR) begin
            tdoPin <= irShift[0];
         end else if (tapState == TAP_SH_DR) begin
            tdoPin <= drBit;
         end
      end
   end

   // configuration loader takes scan-in while configure shifts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         configLoadEnable <= 1'b0;
      end else begin
         configLoadEnable <= activeInstr == INS_CONFIGURE &&
                             tapState == TAP_SH_DR;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // user hooks, registered so they come from flops; this costs one
   // clk of lag behind the sampled tck, negligible at slow test rates
   bst_hooks_t next_userHooks;
   always_comb begin
      next_userHooks.customInstrASelect = activeInstr == INS_CUSTOM_A;
      next_userHooks.customInstrBSelect = activeInstr == INS_CUSTOM_B;
      // clock runs only in capture/shift of a custom register
      next_userHooks.dataRegClockExport =
         (next_userHooks.customInstrASelect |
          next_userHooks.customInstrBSelect) &&
         (tapState == TAP_CAP_DR || tapState == TAP_SH_DR) ? tckS : 1'b1;
      next_userHooks.idleNandOutput = ~(tckS & (tapState == TAP_IDLE));
      next_userHooks.tapResetDecode = tapState == TAP_RESET;
      next_userHooks.tapUpdateDecode = tapState == TAP_UPD_DR;
      next_userHooks.tapShiftDecode = tapState == TAP_SH_DR;
      next_userHooks.scanIn = tdiS;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         userHooks <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      end else begin
         userHooks <= next_userHooks;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait state so read data comes from a flop
   logic ack; // high in the access cycle that completes
   logic hitCtrl, hitStat, hitAny;
   assign hitCtrl = paddr == ADDR_CTRL;
   assign hitStat = paddr == ADDR_STATUS;
   assign hitAny = hitCtrl | hitStat;
   assign pready = psel & penable & ack;
   assign pslverr = pready & ~hitAny;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= psel & penable & ~ack;
      end
   end

   // read data is loaded in the first access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0;
      end else if (psel && penable && !ack) begin
         prdata <= 32'h0;
         if (hitCtrl) begin
            prdata[1:0] <= ctrl;
         end else if (hitStat) begin
            prdata[STAT_STATE_LSB +: 16] <= tapState;
            prdata[STAT_IR_LSB +: IR_W] <= irReg;
            prdata[STAT_DONE_BIT] <= doneS;
            prdata[STAT_KEEP_BIT] <= scanActive;
            prdata[STAT_SPECIAL_BIT] <= bsu[UPD_POS];
         end
      end
   end

   // writes land on the completing edge only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (pready && pwrite && hitCtrl) begin
         ctrl <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_upd_ir;
      tckFall && tapState == TAP_UPD_IR && scanActive;
   endsequence
   sequence s_byp_shift;
      tckRise && tapState == TAP_SH_DR && activeInstr == INS_BYPASS;
   endsequence

   a_reserved_is_bypass: assert property (
      @(posedge clk) disable iff (!rst_n)
      irReg == INS_RESERVED |-> activeInstr == INS_BYPASS)
      else $error("reserved code not treated as bypass");
   a_ir_update_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_upd_ir |=> irReg == $past(irShift))
      else $error("instruction not latched in update-ir");
   a_select_a_decode: assert property (
      @(posedge clk) disable iff (!rst_n)
      userHooks.customInstrASelect == $past(activeInstr == INS_CUSTOM_A))
      else $error("custom select a wrong");
   a_idle_nand_out: assert property (
      @(posedge clk) disable iff (!rst_n)
      ##1 userHooks.idleNandOutput ==
         !($past(tckS) && $past(tapState) == TAP_IDLE))
      else $error("idle output is not the nand");
   a_tms_hold_reset: assert property (
      @(posedge clk) disable iff (!rst_n)
      tapState == TAP_RESET && tmsS && tckRise |=> tapState == TAP_RESET)
      else $error("controller left reset with tms high");
   a_configure_pins_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      activeInstr == INS_CONFIGURE |-> iobPinOe == '0)
      else $error("pins driven during configure");
   a_tap_pads_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      scanActive |-> (iobPinOe & TAP_IOB_MASK) == '0)
      else $error("tap pad output enabled");
   a_bypass_one_bit: assert property (
      @(posedge clk) disable iff (!rst_n)
      s_byp_shift |=> bypassBit == $past(tdiS))
      else $error("bypass flop did not take tdi");
   a_custom_tdo_src: assert property (
      @(posedge clk) disable iff (!rst_n)
      tckFall && tapState == TAP_SH_DR && activeInstr == INS_CUSTOM_B
      |=> tdoPin == $past(customScanOutB) && tdoPinOe)
      else $error("tdo not from custom scan-out b");
   a_extest_capture: assert property (
      @(posedge clk) disable iff (!rst_n)
      tckRise && tapState == TAP_CAP_DR && extestOn
      |=> bsr[4] == $past(iobPinIn[0]) && bsr[2] == $past(iobPinOe[0]))
      else $error("extest capture missed a cell");

endmodule : bst_tap_logic

`default_nettype wire

// File: verification/bst_tester.sv
// test controller model that drives the tap pins of the scan block
// assumes clk is the bench clock; one tck period is eight clk periods
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
   input wire logic clk,
   output logic tckPin,
   output logic tmsPin,
   output logic tdiPin,
   input wire logic tdoPin
);
   // tck rests high between frames, tms high keeps the tap in reset
   initial begin
      tckPin = 1'b1;
      tmsPin = 1'b1;
      tdiPin = 1'b0;
   end
   ////////////////////////////////////////
   // one tck period; tdo is taken at the edge where tck rises
   task automatic tick(input logic tms, input logic tdi, output logic tdo);
      tckPin <= 1'b0;
      tmsPin <= tms;
      tdiPin <= tdi;
      repeat (4) @(posedge clk);
      tdo = tdoPin;
      tckPin <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : tick
   // five tms-high periods reach reset from any state, no reset pin
   task automatic tapReset();
      logic b;
      repeat (5) tick(1'b1, 1'b0, b);
   endtask : tapReset
   // idle to shift, n bits lsb first, then update and back to idle
   task automatic scan(input logic isIr, input int n,
         input logic [31:0] din, output logic [31:0] dout);
      logic b;
      dout = '0;
      tick(1'b1, 1'b0, b);
      if (isIr) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], b);
         dout[i] = b;
      end
      // released tdi shows the inverse so stale data never looks valid
      tick(1'b1, ~din[n-1], b);
      tick(1'b0, ~din[n-1], b);
   endtask : scan
endmodule : bst_tester
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench: apb control and tap scans through the tester
// assumes eight io blocks, the top one masked as a tap input pad
`timescale 1ns/1ps
`default_nettype none
module testbench import bst_pkg::*;;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, b;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, dout, pat, exp;
   logic tckPin, tmsPin, tdiPin, tdoPin, tdoPinOe, tapPinsDedicated;
   logic configDonePin, readbackData, configDout, configLoadEnable;
   logic customScanOutA, customScanOutB;
   logic [7:0] iobPinIn, iobPinOut, iobPinOe, coreOut, coreOe, coreIn;
   logic [7:0] seen; // cells picked out of a boundary scan
   logic [4:0] seenHook; // load enable, shift, update, drck low, scan-in
   logic tdoLine, clrSeen; // tdo as the tester sees it; sticky clear
   bst_hooks_t userHooks;
   int nMismatch = 0;
   int checkCount = 0;
   int cycles = 0;
   // 10 MHz bench clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   bst_tap_logic #(.TAP_IOB_MASK(8'h80)) dut (.clk, .rst_n, .psel,
      .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tckPin, .tmsPin, .tdiPin,
      .tdoPin, .tdoPinOe, .tapPinsDedicated, .configDonePin, .readbackData,
      .configDout, .configLoadEnable, .iobPinIn, .iobPinOut, .iobPinOe,
      .coreOut, .coreOe, .coreIn, .customScanOutA, .customScanOutB,
      .userHooks);
   // an undriven tdo line floats to its pull-up level
   assign tdoLine = tdoPinOe ? tdoPin : 1'b1;
   bst_tester tester (.clk, .tckPin, .tmsPin, .tdiPin, .tdoPin(tdoLine));
   ////////////////////////////////////////
   // one compare for every kind of result
   task automatic check(input string name, input logic [31:0] expv,
         input logic [31:0] got);
      checkCount++;
      if (got !== expv) begin
         nMismatch++;
         $display("BAD %s expected %h seen %h", name, expv, got);
      end
   endtask : check
   // apb transfer; waits for pready without assuming a latency
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk); // idle edge before any next setup
   endtask : apb
   task automatic finish_test();
      if (nMismatch == 0 && checkCount > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // a hang counts as a mismatch; real run is near 1950 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         nMismatch++;
         finish_test();
      end
   end
   // sticky record of hook activity during one data scan
   always @(posedge clk) begin
      if (clrSeen) begin
         seenHook <= '0;
      end else begin
         seenHook <= seenHook | {configLoadEnable, userHooks.tapShiftDecode,
            userHooks.tapUpdateDecode, ~userHooks.dataRegClockExport,
            userHooks.scanIn};
      end
   end
   ////////////////////////////////////////
   initial begin
      {rst_n, clrSeen, psel, penable, pwrite, paddr, pwdata} = '0;
      {configDonePin, configDout, customScanOutB, coreOut} = '0;
      {readbackData, customScanOutA, coreOe, iobPinIn} = {2'h3, 16'hff5a};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("hooks", 32'h38, 32'(userHooks));
      apb(1'b0, ADDR_STATUS, '0);
      check("status", 32'h170001, rd & 32'h1fffff);
      apb(1'b1, 12'h100, 32'h3);
      apb(1'b0, 12'h100, '0);
      check("unmapped", 32'h1, {rd[30:0], err});
      apb(1'b1, ADDR_CTRL, 32'h2);
      apb(1'b0, ADDR_CTRL, '0);
      check("ctrl", 32'h2, rd);
      tester.tapReset();
      check("reset decode", 32'h1, 32'(userHooks.tapResetDecode));
      tester.tick(1'b0, 1'b0, b);
      repeat (2) @(posedge clk);
      check("idle nand", 32'h0, 32'(userHooks.idleNandOutput));
      // extest: enable cells set, out cells alternate, update cell set
      pat = 32'h4000000;
      for (int k = 0; k < 8; k++) begin
         pat[2+3*k] = 1'b1;
         pat[3+3*k] = k[0];
      end
      tester.scan(1'b1, 3, 32'(INS_EXTEST), dout);
      check("ir capture", 32'(IR_CAPTURE_VAL), dout);
      tester.scan(1'b0, 27, pat, dout);
      check("extest oe", 32'h7f, 32'(iobPinOe));
      check("extest out", 32'haa, 32'(iobPinOut));
      check("core in", 32'h5a, 32'(coreIn));
      apb(1'b0, ADDR_STATUS, '0);
      check("update cell", 32'h1, 32'(rd[STAT_SPECIAL_BIT]));
      tester.scan(1'b0, 27, pat, dout);
      for (int k = 0; k < 8; k++) seen[k] = dout[4+3*k];
      check("capture in", 32'h5a, 32'(seen));
      for (int k = 0; k < 8; k++) seen[k] = dout[3+3*k];
      check("capture out", 32'haa, 32'(seen));
      // every other code: tdo source (not for sample), selects, pin drive, decode
      for (int c = 1; c < 8; c++) begin
         tester.scan(1'b1, 3, 32'(c), dout);
         clrSeen <= 1'b1; // forget hooks seen before this data scan
         @(posedge clk);
         clrSeen <= 1'b0;
         tester.scan(1'b0, 4, 32'hb, dout);
         if (c == 2 || c == 4) exp = 32'hf;
         else if (c == 3 || c == 5) exp = 32'h0;
         else exp = 32'h6;
         if (c > 1) check("dr out", exp, dout);
         check("select", 32'({c == 2, c == 3}), 32'({userHooks[7:6]}));
         check("pin oe", (c == 5) ? 32'h0 : 32'h7f, 32'(iobPinOe));
         check("hooks seen", 32'({c == 5, 2'h3, c == 2 || c == 3, 1'b1}),
               32'(seenHook));
         apb(1'b0, ADDR_STATUS, '0);
         check("ir", 32'(c), 32'(rd[18:16]));
      end
      // configured without keep: tap stays in reset
      configDonePin <= 1'b1; // scans only after configuration
      apb(1'b1, ADDR_CTRL, 32'h0);
      tester.scan(1'b1, 3, 32'h2, dout);
      apb(1'b0, ADDR_STATUS, '0);
      check("held reset", 32'(TAP_RESET), 32'(rd[15:0]));
      check("tdo oe", 32'h0, 32'(tdoPinOe));
      apb(1'b1, ADDR_CTRL, 32'h1);
      @(posedge clk);
      check("dedicated", 32'h1, 32'(tapPinsDedicated));
      tester.tick(1'b0, 1'b0, b);
      tester.scan(1'b1, 3, 32'h2, dout);
      tester.scan(1'b0, 4, 32'hb, dout);
      check("custom locked", 32'h6, dout);
      finish_test();
   end
endmodule : testbench
`default_nettype wire
